// file: verilog/pcg_periph_gating.sv
// Local design decision: the address-and-strobe port.
`default_nettype none
module pcg_periph_gating
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // register port
  input  wire pcg_bus_req_t               busReq,
  output logic [31:0]                     busRdata,
  // power state from the power controller
  input  wire pcg_mode_t                  powerMode,
  // peripheral access check
  input  wire pcg_access_t                periphAccess,
  output pcg_access_resp_t                periphResp,
  // gated clocks and enables
  output logic [PCG_NUM_UNITS-1:0]        periphClk,
  output logic [PCG_NUM_UNITS-1:0]        periphEnable,
  // interrupt
  output logic                            irq
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic runSel;
  logic sleepSel;
  logic deepSel;
  logic cfgSel;
  logic statSel;
  logic ienSel;
  logic clrSel;
  logic effSel;
  logic infoSel;

  assign runSel   = busReq.addr == PCG_RUN_GATE_OFS;
  assign sleepSel = busReq.addr == PCG_SLEEP_GATE_OFS;
  assign deepSel  = busReq.addr == PCG_DEEP_GATE_OFS;
  assign cfgSel   = busReq.addr == PCG_RUN_CFG_OFS;
  assign statSel  = busReq.addr == PCG_IRQ_STAT_OFS;
  assign ienSel   = busReq.addr == PCG_IRQ_EN_OFS;
  assign clrSel   = busReq.addr == PCG_IRQ_CLR_OFS;
  assign effSel   = busReq.addr == PCG_EFF_GATE_OFS;
  assign infoSel  = busReq.addr == PCG_FAULT_INFO_OFS;

  // ----------------------------------------
  // gating registers
  // ----------------------------------------
  logic [31:0] runGate_reg;
  logic [31:0] sleepGate_reg;
  logic [31:0] deepGate_reg;
  logic [31:0] runCfg_reg;

  // reserved bits are masked off, so they stay zero whatever is written
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      runGate_reg <= PCG_GATE_RESET;
    end else if (busReq.wr && runSel) begin
      runGate_reg <= busReq.wdata & PCG_GATE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sleepGate_reg <= PCG_GATE_RESET;
    end else if (busReq.wr && sleepSel) begin
      sleepGate_reg <= busReq.wdata & PCG_GATE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deepGate_reg <= PCG_GATE_RESET;
    end else if (busReq.wr && deepSel) begin
      deepGate_reg <= busReq.wdata & PCG_GATE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      runCfg_reg <= PCG_RUN_CFG_RESET;
    end else if (busReq.wr && cfgSel) begin
      runCfg_reg <= busReq.wdata & PCG_RUN_CFG_MASK;
    end
  end

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  logic        autoGate;
  logic [31:0] effGate_next;
  logic [31:0] effGate_reg;

  assign autoGate = runCfg_reg[PCG_AUTO_GATE_POS];

  always_comb begin
    effGate_next = runGate_reg;
    case (powerMode)
      PCG_MODE_RUN: begin
        effGate_next = runGate_reg;
      end
      PCG_MODE_SLEEP: begin
        effGate_next = autoGate ? sleepGate_reg : runGate_reg;
      end
      PCG_MODE_DEEP: begin
        effGate_next = autoGate ? deepGate_reg : runGate_reg;
      end
      default: begin
        effGate_next = runGate_reg;
      end
    endcase
  end

  // registered so enables never carry decode hazards into the gates
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      effGate_reg <= PCG_GATE_RESET;
    end else begin
      effGate_reg <= effGate_next;
    end
  end

  // ----------------------------------------
  // per-unit gates
  // ----------------------------------------
  logic [PCG_NUM_UNITS-1:0] unitEn;

  genvar gi;
  generate
    for (gi = 0; gi < PCG_NUM_UNITS; gi++) begin : g_unit
      assign unitEn[gi] = effGate_reg[PCG_UNIT_POS[gi]];

      pcg_clock_gate u_gate (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .gateEn   (unitEn[gi]),
        .gatedClk (periphClk[gi])
      );
    end
  endgenerate

  // unit held in its disabled state whenever its clock is off
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      periphEnable <= '0;
    end else begin
      periphEnable <= unitEn;
    end
  end

  // ----------------------------------------
  // access check
  // ----------------------------------------
  logic unitIdxOk;
  logic accClocked;
  logic accFault;

  assign unitIdxOk  = periphAccess.unit < 3'(PCG_NUM_UNITS);
  assign accClocked = unitIdxOk && unitEn[periphAccess.unit];
  // an index past the last unit is unmapped and faults as well
  assign accFault   = periphAccess.valid && !accClocked;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      periphResp <= '0;
    end else begin
      periphResp.ok    <= periphAccess.valid && accClocked;
      periphResp.fault <= accFault;
    end
  end

  // last fault: unit index in 2:0, write flag in 3
  logic [3:0] faultInfo_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      faultInfo_reg <= 4'h0;
    end else if (accFault) begin
      faultInfo_reg <= {periphAccess.write, periphAccess.unit};
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  pcg_mode_t             lastMode_reg;
  logic [PCG_IRQ_W-1:0]  irqEvent;
  logic [PCG_IRQ_W-1:0]  irqStat_reg;
  logic [PCG_IRQ_W-1:0]  irqEn_reg;
  logic [PCG_IRQ_W-1:0]  irqClr;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lastMode_reg <= PCG_MODE_RUN;
    end else begin
      lastMode_reg <= powerMode;
    end
  end

  always_comb begin
    irqEvent = '0;
    irqEvent[PCG_IRQ_FAULT_POS] = accFault;
    irqEvent[PCG_IRQ_MODE_POS]  = powerMode != lastMode_reg;
  end

  assign irqClr = (busReq.wr && clrSel) ? busReq.wdata[PCG_IRQ_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStat_reg <= PCG_IRQ_RESET;
    end else begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqEn_reg <= PCG_IRQ_RESET;
    end else if (busReq.wr && ienSel) begin
      irqEn_reg <= busReq.wdata[PCG_IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_reg & irqEn_reg);

  // ----------------------------------------
  // read back
  // ----------------------------------------
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (runSel) begin
      rdata_next = runGate_reg;
    end else if (sleepSel) begin
      rdata_next = sleepGate_reg;
    end else if (deepSel) begin
      rdata_next = deepGate_reg;
    end else if (cfgSel) begin
      rdata_next = runCfg_reg;
    end else if (statSel) begin
      rdata_next[PCG_IRQ_W-1:0] = irqStat_reg;
    end else if (ienSel) begin
      rdata_next[PCG_IRQ_W-1:0] = irqEn_reg;
    end else if (effSel) begin
      rdata_next = effGate_reg;
    end else if (infoSel) begin
      rdata_next[3:0] = faultInfo_reg;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busRdata <= 32'h0000_0000;
    end else if (busReq.rd) begin
      busRdata <= rdata_next;
    end else begin
      busRdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: verilog/pcg_pkg.sv
`default_nettype none
package pcg_pkg;

  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [11:0] PCG_RUN_GATE_OFS   = 12'h104;
  localparam logic [11:0] PCG_SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] PCG_DEEP_GATE_OFS  = 12'h124;
  localparam logic [11:0] PCG_RUN_CFG_OFS    = 12'h060;
  localparam logic [11:0] PCG_IRQ_STAT_OFS   = 12'h130;
  localparam logic [11:0] PCG_IRQ_EN_OFS     = 12'h134;
  localparam logic [11:0] PCG_IRQ_CLR_OFS    = 12'h138;
  localparam logic [11:0] PCG_EFF_GATE_OFS   = 12'h13C;
  localparam logic [11:0] PCG_FAULT_INFO_OFS = 12'h140;

  // ----------------------------------------
  // gating register layout
  // ----------------------------------------
  localparam int PCG_NUM_UNITS = 7;
  localparam int PCG_ASYNC0_POS  = 0;
  localparam int PCG_ASYNC1_POS  = 1;
  localparam int PCG_SYNC0_POS   = 4;
  localparam int PCG_TWOWIRE_POS = 12;
  localparam int PCG_CNT0_POS    = 16;
  localparam int PCG_CNT1_POS    = 17;
  localparam int PCG_CNT2_POS    = 18;
  localparam int PCG_UNIT_POS [PCG_NUM_UNITS] = '{
    PCG_ASYNC0_POS, PCG_ASYNC1_POS, PCG_SYNC0_POS, PCG_TWOWIRE_POS,
    PCG_CNT0_POS, PCG_CNT1_POS, PCG_CNT2_POS};
  localparam logic [31:0] PCG_GATE_MASK  = 32'h0007_1013;
  localparam logic [31:0] PCG_GATE_RESET = 32'h0000_0000;

  // ----------------------------------------
  // other fields
  // ----------------------------------------
  localparam int PCG_AUTO_GATE_POS = 27;
  localparam logic [31:0] PCG_RUN_CFG_MASK  = 32'h0800_0000;
  localparam logic [31:0] PCG_RUN_CFG_RESET = 32'h0000_0000;
  localparam int PCG_IRQ_FAULT_POS = 0;
  localparam int PCG_IRQ_MODE_POS  = 1;
  localparam int PCG_IRQ_W         = 2;
  localparam logic [1:0] PCG_IRQ_RESET = 2'h0;

  typedef enum logic [1:0] {
    PCG_MODE_RUN   = 2'h0,
    PCG_MODE_SLEEP = 2'h1,
    PCG_MODE_DEEP  = 2'h3
  } pcg_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcg_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] unit;
  } pcg_access_t;

  typedef struct packed {
    logic       ok;
    logic       fault;
  } pcg_access_resp_t;

endpackage
`default_nettype wire

// file: verilog/pcg_clock_gate.sv
`default_nettype none
module pcg_clock_gate
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // enable and gated clock
  input  wire logic gateEn,
  output logic      gatedClk
);

  // ----------------------------------------
  // glitch-free gate
  // ----------------------------------------
  // enable moves only while the clock is low, so the and never chops a pulse
  logic enLow_reg;

  always_ff @(negedge core_clk) begin
    if (sys_rst) begin
      enLow_reg <= 1'b0;
    end else begin
      enLow_reg <= gateEn;
    end
  end

  assign gatedClk = core_clk & enLow_reg;

endmodule
`default_nettype wire

// file: sim/pcg_periph_model.sv
`default_nettype none
module pcg_periph_model
  import pcg_pkg::*;
(
  // control
  input  wire logic                     clr,
  // gated clocks
  input  wire logic [PCG_NUM_UNITS-1:0] periphClk,
  // edges seen per unit
  output logic      [7:0]               tickCnt [PCG_NUM_UNITS]
);
  timeunit 1ns;
  timeprecision 1ps;
  // a stopped unit sees no edge, so its count freezes
  for (genvar i = 0; i < PCG_NUM_UNITS; i++) begin : g_unit
    always_ff @(posedge periphClk[i] or posedge clr) begin
      if (clr) begin
        tickCnt[i] <= 8'h00;
      end else if (tickCnt[i] != 8'hFF) begin
        tickCnt[i] <= tickCnt[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/pcg_periph_gating_monitor.sv
`default_nettype none
module pcg_periph_gating_monitor
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     sys_rst,
  // observed ports
  input wire pcg_bus_req_t             busReq,
  input wire logic [31:0]              busRdata,
  input wire pcg_access_t              periphAccess,
  input wire pcg_access_resp_t         periphResp,
  input wire logic [PCG_NUM_UNITS-1:0] periphClk,
  input wire logic [PCG_NUM_UNITS-1:0] periphEnable,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lastUnit;
  logic       req;
  assign req = periphAccess.valid && periphAccess.unit != 3'h7;
  always_ff @(posedge core_clk) lastUnit <= periphAccess.unit;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // enable may trail the gate register by a cycle, so two samples must agree
  property p_flt_off;
    @(posedge core_clk) disable iff (sys_rst)
      (req && !periphEnable[periphAccess.unit]) ##1 !periphEnable[lastUnit] |-> periphResp == 2'h1;
  endproperty
  a_flt_off: assert property (p_flt_off) else $error("stopped unit not faulted");
  property p_ok_on;
    @(posedge core_clk) disable iff (sys_rst)
      (req && periphEnable[periphAccess.unit]) ##1 periphEnable[lastUnit] |-> periphResp == 2'h2;
  endproperty
  a_ok_on: assert property (p_ok_on) else $error("clocked unit refused");
  property p_unit7;
    @(posedge core_clk) disable iff (sys_rst)
      periphAccess.valid && periphAccess.unit == 3'h7 |=> periphResp == 2'h1;
  endproperty
  a_unit7: assert property (p_unit7) else $error("unmapped unit not faulted");
  property p_no_resp;
    @(posedge core_clk) disable iff (sys_rst) !periphAccess.valid |=> periphResp == 2'h0;
  endproperty
  a_no_resp: assert property (p_no_resp) else $error("response without access");
  property p_rsvd;
    @(posedge core_clk) disable iff (sys_rst)
      busReq.rd && busReq.addr inside {12'h104, 12'h114, 12'h124}
      |=> (busRdata & 32'hFFF8_EFEC) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved gate bit reads one");
  property p_rst;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> periphEnable == 7'h00 && busRdata == 32'h0 && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  // high phase of a gated clock is seen in the preponed value at the falling edge
  property p_gclk_off;
    @(negedge core_clk) disable iff (sys_rst)
      (periphClk & ~($past(periphEnable) | periphEnable)) == 7'h00;
  endproperty
  a_gclk_off: assert property (p_gclk_off) else $error("clock runs while disabled");
  property p_gclk_on;
    @(negedge core_clk) disable iff (sys_rst)
      ($past(periphEnable) & periphEnable & ~periphClk) == 7'h00;
  endproperty
  a_gclk_on: assert property (p_gclk_on) else $error("clock missing while enabled");
endmodule
bind pcg_periph_gating pcg_periph_gating_monitor u_mon (
  .core_clk    (core_clk),
  .sys_rst     (sys_rst),
  .busReq      (busReq),
  .busRdata    (busRdata),
  .periphAccess(periphAccess),
  .periphResp  (periphResp),
  .periphClk   (periphClk),
  .periphEnable(periphEnable),
  .irq         (irq)
);
`default_nettype wire

// file: sim/pcg_periph_gating_tb_top.sv
`default_nettype none
module pcg_periph_gating_tb_top
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [11:0] ofs;
    logic [31:0] wdata;
    logic [31:0] exp;
  } pcg_row_t;
  logic                     core_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  pcg_bus_req_t             busReq = '0;
  logic [31:0]              busRdata;
  pcg_mode_t                powerMode = PCG_MODE_RUN;
  pcg_access_t              periphAccess = '0;
  pcg_access_resp_t         periphResp;
  logic [PCG_NUM_UNITS-1:0] periphClk;
  logic [PCG_NUM_UNITS-1:0] periphEnable;
  logic                     irq;
  logic                     tickClr = 1'b0;
  logic [7:0]               tickCnt [PCG_NUM_UNITS];
  logic [31:0]              rdVal;
  int                       errCount = 0;
  int                       cmpCount = 0;
  logic [4:0]               unitBit [7] = '{0, 1, 4, 12, 16, 17, 18};
  pcg_mode_t                modes [3] = '{PCG_MODE_SLEEP, PCG_MODE_DEEP, PCG_MODE_RUN};
  logic [6:0]               modeExp [3] = '{7'h02, 7'h10, 7'h01};
  pcg_row_t                 rows [7] = '{
    '{12'h104, 32'h0000_0000, 32'h0000_0000},
    '{12'h104, 32'hFFFF_FFFF, 32'h0007_1013},
    '{12'h114, 32'hFFFF_FFFF, 32'h0007_1013},
    '{12'h124, 32'h0000_1012, 32'h0000_1012},
    '{12'h114, 32'h0007_0001, 32'h0007_0001},
    '{12'h060, 32'hFFFF_FFFF, 32'h0800_0000},
    '{12'h200, 32'hFFFF_FFFF, 32'h0000_0000}};
  always #10 core_clk = ~core_clk;
  pcg_periph_gating uut (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq),
    .busRdata(busRdata), .powerMode(powerMode), .periphAccess(periphAccess),
    .periphResp(periphResp), .periphClk(periphClk), .periphEnable(periphEnable), .irq(irq));
  pcg_periph_model u_model (.clr(tickClr), .periphClk(periphClk), .tickCnt(tickCnt));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic regWr(logic [11:0] ofs, logic [31:0] data);
    @(posedge core_clk);
    busReq <= '{addr: ofs, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    #1;
  endtask
  task automatic regRd(logic [11:0] ofs);
    @(posedge core_clk);
    busReq <= '{addr: ofs, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 rdVal = busRdata;
  endtask
  task automatic access(logic [2:0] unit, logic expFault);
    @(posedge core_clk);
    periphAccess <= '{valid: 1'b1, write: unit[0], unit: unit};
    @(posedge core_clk);
    periphAccess.valid <= 1'b0;
    #1 check("fault", periphResp.fault, expFault);
    check("ok", periphResp.ok, !expFault);
  endtask
  task automatic reportAndStop();
    if (errCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    access(3'h0, 1'b1);
    foreach (rows[i]) begin
      regWr(rows[i].ofs, rows[i].wdata);
      regRd(rows[i].ofs);
      check("readback", rdVal, rows[i].exp);
    end
    regWr(12'h060, 32'h0);
    for (int u = 0; u < PCG_NUM_UNITS; u++) begin
      regWr(12'h104, 32'h1 << unitBit[u]);
      tickClr = 1'b1;
      repeat (3) @(posedge core_clk);
      tickClr = 1'b0;
      repeat (4) @(posedge core_clk);
      #1 check("enable", periphEnable, 7'h01 << u);
      for (int v = 0; v < PCG_NUM_UNITS; v++) begin
        check("ticks", tickCnt[v] != 8'h00, v == u);
        access(3'(v), v != u);
      end
    end
    access(3'h7, 1'b1);
    regRd(12'h104);
    regWr(12'h104, (rdVal & 32'hFFF8_EFEC) | 32'h1);
    regWr(12'h114, 32'h2);
    regWr(12'h124, 32'h1_0000);
    for (int a = 0; a < 2; a++) begin
      regWr(12'h060, a ? 32'h0800_0000 : 32'h0);
      foreach (modes[m]) begin
        @(posedge core_clk);
        powerMode <= modes[m];
        repeat (3) @(posedge core_clk);
        #1 check("modeEnable", periphEnable, a ? modeExp[m] : 7'h01);
      end
    end
    regRd(12'h130);
    check("modeEvent", rdVal[1], 1'b1);
    regWr(12'h138, 32'h3);
    regWr(12'h134, 32'h0);
    access(3'h2, 1'b1);
    check("irqMasked", irq, 1'b0);
    regRd(12'h140);
    check("faultInfo", rdVal, 32'h0000_0002);
    regRd(12'h13C);
    check("effGate", rdVal, 32'h0000_0001);
    regRd(12'h130);
    check("status", rdVal[0], 1'b1);
    regWr(12'h134, 32'h1);
    check("irqOn", irq, 1'b1);
    regWr(12'h138, 32'h1);
    check("irqOff", irq, 1'b0);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    regRd(12'h104);
    check("rstRun", rdVal, 32'h0);
    reportAndStop();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    reportAndStop();
  end
endmodule
`default_nettype wire
